// [rtl/fp_dispatch_pkg.sv]
// fp_dispatch_pkg: constants shared by the floating-point dispatch block
// assumes a single 125 MHz clock domain and a 16-bit command/response pair
package fp_dispatch_pkg;

   // ----------------------------------------------------------------
   // response primitive fields and encodings
   // ----------------------------------------------------------------
   localparam int COME_AGAIN_BIT = 15;
   localparam int INTS_ALLOWED_BIT = 8;
   localparam logic [15:0] PRIM_RELEASE = 16'h0800;   // null, come-again clear
   localparam logic [15:0] PRIM_NULL_WAIT = 16'h8900; // null, come-again and interrupts-allowed
   localparam logic [15:0] PRIM_XFER = 16'h1500;      // transfer operand, come-again clear
   localparam logic [15:0] PRIM_EXC = 16'h1C30;       // pre-instruction exception
   localparam logic [15:0] RESP_RESET = PRIM_RELEASE;

   // ----------------------------------------------------------------
   // command word fields
   // ----------------------------------------------------------------
   localparam int CLS_LSB = 13;
   localparam int FMT_LSB = 10;
   localparam int SRC_LSB = 7;
   localparam int DST_LSB = 4;

   // instruction classes
   localparam logic [2:0] CLS_ARITH = 3'h0;  // arithmetic, memory operand
   localparam logic [2:0] CLS_MOVE = 3'h1;   // extended register-to-register move
   localparam logic [2:0] CLS_ROM = 3'h2;    // constant load into a register
   localparam logic [2:0] CLS_MULTI = 3'h3;  // multiple-register move

   // operand formats
   localparam logic [2:0] FMT_L = 3'h0;
   localparam logic [2:0] FMT_S = 3'h1;
   localparam logic [2:0] FMT_X = 3'h2;
   localparam logic [2:0] FMT_P = 3'h3;
   localparam logic [2:0] FMT_W = 3'h4;
   localparam logic [2:0] FMT_D = 3'h5;
   localparam logic [2:0] FMT_B = 3'h6;

   // ----------------------------------------------------------------
   // timing and storage
   // ----------------------------------------------------------------
   localparam int CNT_W = 8;
   localparam int ARITH_CYCLES_DEF = 8;
   localparam logic [7:0][31:0] ROM_CONSTS = {
      32'h0000_0007, 32'h0000_0006, 32'h0000_0005, 32'h0000_0004,
      32'h0000_0003, 32'h0000_0002, 32'h0000_0001, 32'h0000_0000
   };

endpackage

// [rtl/operand_convert.sv]
// operand_convert: brings a host operand into the internal word format
// assumes the format code is stable while the operand is presented
`timescale 1ns/1ns
`default_nettype none
module operand_convert
   import fp_dispatch_pkg::*;
#(
   parameter int WIDTH = 32
) (
   input wire logic [2:0] fmt,
   input wire logic [WIDTH-1:0] data_in,
   output logic [WIDTH-1:0] data_out
);

   // sign extension of short integers, others pass unchanged
   always_comb begin
      case (fmt)
         FMT_B: data_out = {{(WIDTH-8){data_in[7]}}, data_in[7:0]};
         FMT_W: data_out = {{(WIDTH-16){data_in[15]}}, data_in[15:0]};
         default: data_out = data_in;
      endcase
   end

endmodule // operand_convert
`default_nettype wire

// [rtl/fp_coproc_concurrency_dispatch.sv]
// fp_coproc_concurrency_dispatch: command dispatch, arithmetic unit and
// conversion unit of a floating-point coprocessor seen from its host port
// assumes the host polls resp_word after each cmd_wr and honours come-again
`timescale 1ns/1ns
`default_nettype none

module fp_coproc_concurrency_dispatch
   import fp_dispatch_pkg::*;
#(
   parameter bit ENHANCED = 1'b1,
   parameter int ARITH_CYCLES = ARITH_CYCLES_DEF
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic cmd_wr,
   input wire logic [15:0] cmd_word,
   input wire logic opnd_wr,
   input wire logic [31:0] opnd_data,
   output logic [15:0] resp_word,
   output logic arith_busy,
   output logic cu_busy,
   input wire logic [2:0] reg_rd_sel,
   output logic [31:0] reg_rd_data
);

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      S_IDLE = 2'b00,
      S_HOLD = 2'b01,
      S_XFER = 2'b10
   } front_t;

   typedef struct packed {
      front_t st;
      logic [2:0] cls;
      logic [2:0] fmt;
      logic [2:0] src;
      logic [2:0] dst;
      logic [15:0] resp;
      logic exc;
      logic a_busy;
      logic [CNT_W-1:0] a_cnt;
      logic [2:0] a_dst;
      logic a_load;
      logic [31:0] a_opnd;
      logic c_valid;
      logic c_move;
      logic c_load;
      logic c_fetched;
      logic [2:0] c_src;
      logic [2:0] c_dst;
      logic [31:0] c_opnd;
      logic [7:0][31:0] regs;
   } state_t;

   localparam logic [CNT_W-1:0] ARITH_LAST = CNT_W'(ARITH_CYCLES - 1);

   state_t q;
   state_t d;
   logic [31:0] conv_val;
   logic [32:0] sum;
   logic exc_set;
   logic exc_clr;
   logic need_idle;
   logic can_go;
   logic start_now;
   logic [2:0] start_dst;
   logic [31:0] start_opnd;
   logic start_load;

   // ----------------------------------------------------------------
   // operand conversion to internal format
   // ----------------------------------------------------------------
   operand_convert #(
      .WIDTH(32)
   ) u_convert (
      .fmt(q.fmt),
      .data_in(opnd_data),
      .data_out(conv_val)
   );

   // ----------------------------------------------------------------
   // next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      d = q;
      exc_set = 1'b0;
      exc_clr = 1'b0;
      start_now = 1'b0;
      start_dst = '0;
      start_opnd = '0;
      start_load = 1'b0;
      sum = {1'b0, q.regs[q.a_dst]} + {1'b0, q.a_opnd};

      // arithmetic unit: add or load apart from the host
      if (q.a_busy) begin
         if (q.a_cnt == '0) begin
            d.regs[q.a_dst] = q.a_load ? q.a_opnd : sum[31:0];
            exc_set = ~q.a_load & sum[32];
            d.a_busy = 1'b0;
         end else begin
            d.a_cnt = q.a_cnt - 1'b1;
         end
      end

      // conversion unit: work on the held instruction
      if (q.c_valid) begin
         if (q.c_move) begin
            if (!q.c_fetched) begin
               if (!(q.a_busy && q.a_dst == q.c_src)) begin
                  d.c_opnd = q.regs[q.c_src];
                  d.c_fetched = 1'b1;
               end
            end else if (!(q.a_busy && q.a_dst == q.c_dst)) begin
               d.regs[q.c_dst] = q.c_opnd;
               d.c_valid = 1'b0;
            end
         end else if (!q.a_busy) begin
            start_now = 1'b1;
            start_dst = q.c_dst;
            start_opnd = q.c_opnd;
            start_load = q.c_load;
            d.c_valid = 1'b0;
         end
      end

      // front end: packed, constant and multi-register wait for idle
      need_idle = !ENHANCED || q.cls == CLS_ROM || q.cls == CLS_MULTI
         || (q.cls == CLS_ARITH && q.fmt == FMT_P);
      can_go = !q.c_valid && !(need_idle && q.a_busy);

      // front end: command and response sequencing
      case (q.st)
         S_IDLE: begin
            if (cmd_wr) begin
               d.cls = cmd_word[CLS_LSB +: 3];
               d.fmt = cmd_word[FMT_LSB +: 3];
               d.src = cmd_word[SRC_LSB +: 3];
               d.dst = cmd_word[DST_LSB +: 3];
               d.resp = PRIM_NULL_WAIT;
               d.st = S_HOLD;
            end
         end
         S_HOLD: begin
            if (q.exc) begin
               d.resp = PRIM_EXC;
               exc_clr = 1'b1;
               d.st = S_IDLE;
            end else if (can_go) begin
               case (q.cls)
                  CLS_MOVE: begin
                     d.resp = PRIM_RELEASE;
                     d.c_valid = 1'b1;
                     d.c_move = 1'b1;
                     d.c_load = 1'b0;
                     d.c_fetched = 1'b0;
                     d.c_src = q.src;
                     d.c_dst = q.dst;
                     d.st = S_IDLE;
                  end
                  CLS_ROM: begin
                     d.resp = PRIM_RELEASE;
                     start_now = 1'b1;
                     start_dst = q.dst;
                     start_opnd = ROM_CONSTS[q.src];
                     start_load = 1'b1;
                     d.st = S_IDLE;
                  end
                  default: begin
                     d.resp = PRIM_XFER;
                     d.st = S_XFER;
                  end
               endcase
            end
         end
         S_XFER: begin
            if (opnd_wr) begin
               d.resp = PRIM_RELEASE;
               d.st = S_IDLE;
               if (!q.a_busy && !q.c_valid) begin
                  start_now = 1'b1;
                  start_dst = q.dst;
                  start_opnd = conv_val;
                  start_load = (q.cls == CLS_MULTI);
               end else begin
                  d.c_valid = 1'b1;
                  d.c_move = 1'b0;
                  d.c_load = (q.cls == CLS_MULTI);
                  d.c_fetched = 1'b1;
                  d.c_dst = q.dst;
                  d.c_opnd = conv_val;
               end
            end
         end
         default: begin
            d.st = S_IDLE;
         end
      endcase

      // arithmetic start from either source
      if (start_now) begin
         d.a_busy = 1'b1;
         d.a_cnt = ARITH_LAST;
         d.a_dst = start_dst;
         d.a_opnd = start_opnd;
         d.a_load = start_load;
      end

      // exception flag: a new event wins over the report
      d.exc = (q.exc & ~exc_clr) | exc_set;
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         q <= '0;
         q.st <= S_IDLE;
         q.resp <= RESP_RESET;
      end else begin
         q <= d;
      end
   end

   // ----------------------------------------------------------------
   // outputs; response reads alter nothing
   // ----------------------------------------------------------------
   assign resp_word = q.resp;
   assign arith_busy = q.a_busy;
   assign cu_busy = q.c_valid;
   assign reg_rd_data = q.regs[reg_rd_sel];

   // ----------------------------------------------------------------
   // usage notes
   // ----------------------------------------------------------------
   // front end holds one command at a time
   // a command written while a command is held is ignored
   // a command written during the transfer phase is ignored
   // host must wait for come-again clear before the next command
   // transfer primitive asks for exactly one operand word
   // operand strobe outside the transfer phase is ignored
   // null primitive stands while the command is blocked
   // blocked commands keep interrupts-allowed set
   // enhanced variant: conversion unit holds one instruction
   // enhanced variant: a held instruction blocks new commands
   // single variant: any busy arithmetic blocks new commands
   // packed, constant and multi-register always wait for idle
   // register move never uses the arithmetic unit
   // register move waits while arithmetic targets its source
   // register move waits while arithmetic targets its destination
   // destination hazard keeps results in program order
   // constant load starts the arithmetic unit as a plain load
   // multi-register class loads one word after its transfer
   // carry-out of an add sets the sticky exception
   // sticky exception is reported on the next held command
   // reported command is dropped, front returns to idle
   // exception set in the same cycle as a report wins
   // response word only changes on front-end state changes
   // register reads are combinational and side-effect free
   // arithmetic time counts from the starting edge
   // one arithmetic instruction runs at a time
   // conversion unit starts arithmetic only when it is idle
   // reset clears all registers and shows the release primitive
   // format codes other than byte and word pass unchanged
   // host is expected to poll, never to abort a command

endmodule // fp_coproc_concurrency_dispatch
`default_nettype wire

// [tb/dispatch_sva.sv]
// checker: timing relations on the dispatch block ports
// assumes it is bound to the dispatch top module, one clock
`timescale 1ns/1ns
`default_nettype none
module dispatch_sva
   import fp_dispatch_pkg::*;
#(
   parameter int ARITH_CYCLES = 8
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic cmd_wr,
   input wire logic [15:0] cmd_word,
   input wire logic opnd_wr,
   input wire logic [31:0] opnd_data,
   input wire logic [15:0] resp_word,
   input wire logic arith_busy,
   input wire logic cu_busy,
   input wire logic [2:0] reg_rd_sel,
   input wire logic [31:0] reg_rd_data
);
   // ----------
   // helpers
   // ----------
   logic idle;
   logic take;
   logic pk;
   logic [7:0] run_q;
   logic [15:0] cmd_q;
   // front idle, accepted command, held packed command
   assign idle = resp_word == PRIM_RELEASE;
   assign take = cmd_wr && idle && !cu_busy;
   assign pk = cmd_q[15:13] == CLS_ARITH && cmd_q[12:10] == FMT_P;
   // busy run length and last taken command
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         run_q <= 8'h00;
         cmd_q <= 16'h0000;
      end else begin
         run_q <= arith_busy ? run_q + 8'h01 : 8'h00;
         if (cmd_wr && idle)
            cmd_q <= cmd_word;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   // ----------
   // assertions
   // ----------
   AST_TAKE: assert property (cmd_wr && idle |=> resp_word == PRIM_NULL_WAIT)
      else $error("no null after command");
   AST_CA_NULL: assert property (resp_word[COME_AGAIN_BIT] |-> resp_word == PRIM_NULL_WAIT)
      else $error("come-again without null");
   AST_RELEASE: assert property (resp_word == PRIM_XFER && opnd_wr |=> idle && (arith_busy || cu_busy))
      else $error("no release after operand");
   AST_XFER_HOLD: assert property (resp_word == PRIM_XFER && !opnd_wr |=> resp_word == PRIM_XFER)
      else $error("transfer primitive dropped");
   AST_RUN: assert property (arith_busy && run_q < ARITH_CYCLES - 1 |=> arith_busy)
      else $error("arithmetic ended early");
   AST_HANDOFF: assert property (cu_busy && !arith_busy |-> ##[0:6] !cu_busy)
      else $error("conversion unit stuck");
   AST_PACKED: assert property (arith_busy && pk && resp_word == PRIM_NULL_WAIT ##1 arith_busy
      |-> resp_word != PRIM_XFER)
      else $error("packed prefetch while busy");
   AST_MOVE: assert property (take && cmd_word[15:13] == CLS_MOVE |-> ##2 idle)
      else $error("move did not release");
   AST_PREFETCH: assert property (take && cmd_word[15:13] == CLS_ARITH && cmd_word[12:10] != FMT_P
      |-> ##2 resp_word == PRIM_XFER)
      else $error("no operand request");
endmodule // dispatch_sva
bind fp_coproc_concurrency_dispatch dispatch_sva #(.ARITH_CYCLES(ARITH_CYCLES)) u_dispatch_sva (
   .clk(clk), .reset(reset), .cmd_wr(cmd_wr), .cmd_word(cmd_word), .opnd_wr(opnd_wr),
   .opnd_data(opnd_data), .resp_word(resp_word), .arith_busy(arith_busy), .cu_busy(cu_busy),
   .reg_rd_sel(reg_rd_sel), .reg_rd_data(reg_rd_data));
`default_nettype wire

// [tb/host_model.sv]
// host_model: main processor side of the command/response port
// assumes resp_word is registered on the rising edge of clk
`timescale 1ns/1ns
`default_nettype none
module host_model
   import fp_dispatch_pkg::*;
(
   input wire logic clk,
   input wire logic [15:0] resp_word,
   output logic cmd_wr,
   output logic [15:0] cmd_word,
   output logic opnd_wr,
   output logic [31:0] opnd_data
);
   // idle strobes at time zero
   initial begin
      cmd_wr = 1'b0;
      cmd_word = 16'h0000;
      opnd_wr = 1'b0;
      opnd_data = 32'h0000_0000;
   end
   // one instruction: command, poll, operand if asked
   task automatic issue(input logic [15:0] cmd, input logic [31:0] op, output logic [15:0] last);
      int n;
      @(posedge clk);
      #1 cmd_wr = 1'b1;
      cmd_word = cmd;
      @(posedge clk);
      #1 cmd_wr = 1'b0;
      cmd_word = ~cmd;
      n = 0;
      // reread while come-again; a poll cycle stands in for interrupt service
      do begin
         @(posedge clk);
         #1 n++;
      end while (resp_word[COME_AGAIN_BIT] && n < 100);
      last = resp_word;
      if (last === PRIM_XFER) begin
         #1 opnd_wr = 1'b1;
         opnd_data = op;
         @(posedge clk);
         #1 opnd_wr = 1'b0;
         opnd_data = ~op;
      end
   endtask
endmodule // host_model
`default_nettype wire

// [tb/tb_top.sv]
// tb_top: random and directed instruction traffic
// assumes the enhanced variant with a short arithmetic time
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import fp_dispatch_pkg::*;
   localparam int AC = 4;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic cmd_wr;
   logic [15:0] cmd_word;
   logic opnd_wr;
   logic [31:0] opnd_data;
   logic [15:0] resp_word;
   logic arith_busy;
   logic cu_busy;
   logic [2:0] reg_rd_sel = 3'h0;
   logic [31:0] reg_rd_data;
   logic [31:0] exp_reg [8];
   logic [15:0] p;
   logic [31:0] r;
   logic [31:0] op;
   logic [2:0] f;
   int seed = 72811;
   int miscompares = 0;
   int check_count = 0;
   // 125 MHz clock
   always #4 clk = ~clk;
   fp_coproc_concurrency_dispatch #(.ENHANCED(1'b1), .ARITH_CYCLES(AC)) u_fp_coproc_concurrency_dispatch (
      .clk(clk), .reset(reset), .cmd_wr(cmd_wr), .cmd_word(cmd_word), .opnd_wr(opnd_wr),
      .opnd_data(opnd_data), .resp_word(resp_word), .arith_busy(arith_busy), .cu_busy(cu_busy),
      .reg_rd_sel(reg_rd_sel), .reg_rd_data(reg_rd_data));
   host_model u_host_model (.clk(clk), .resp_word(resp_word), .cmd_wr(cmd_wr), .cmd_word(cmd_word),
      .opnd_wr(opnd_wr), .opnd_data(opnd_data));
   // ----------
   // helpers
   // ----------
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      check_count++;
      if (seen !== want) begin
         miscompares++;
         $display("unexpected at %0t: %h vs %h", $time, seen, want);
      end
   endtask
   task automatic summarize();
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   function automatic logic [31:0] sext(input logic [2:0] fm, input logic [31:0] v);
      if (fm == FMT_B)
         return {{24{v[7]}}, v[7:0]};
      if (fm == FMT_W)
         return {{16{v[15]}}, v[15:0]};
      return v;
   endfunction
   task automatic go(input logic [2:0] c, fm, s, d, input logic [31:0] v, input logic [15:0] want);
      u_host_model.issue({c, fm, s, d, 4'h0}, v, p);
      check(32'(p), 32'(want));
   endtask
   // let both units settle, then compare every register
   task automatic drain(input string name);
      int n;
      n = 0;
      @(posedge clk);
      #1;
      while ((arith_busy !== 1'b0 || cu_busy !== 1'b0) && n < 200) begin
         @(posedge clk);
         #1 n++;
      end
      check(32'(n < 200), 32'h1);
      for (int i = 0; i < 8; i++) begin
         reg_rd_sel = 3'(i);
         #1 check(reg_rd_data, exp_reg[i]);
      end
      $display("test %s done", name);
   endtask
   // ----------
   // main sequence
   // ----------
   initial begin
      for (int i = 0; i < 8; i++)
         exp_reg[i] = 32'h0;
      repeat (6) @(posedge clk);
      #1 reset = 1'b0;
      check(32'(resp_word), 32'(RESP_RESET));
      drain("reset");
      for (int i = 0; i < 8; i++) begin
         go(CLS_ROM, FMT_X, 3'(i), 3'(i), 32'h0, PRIM_RELEASE);
         exp_reg[i] = ROM_CONSTS[i];
      end
      drain("constants");
      repeat (40) begin
         r = $random(seed);
         f = r[26] ? FMT_W : (r[27] ? FMT_B : FMT_L);
         op = $random(seed) & (f == FMT_L ? 32'h0000_7F7F : 32'hFFFF_7F7F);
         case (r[25:24])
            2'h0: begin
               go(CLS_MOVE, FMT_X, r[18:16], r[22:20], 32'h0, PRIM_RELEASE);
               exp_reg[r[22:20]] = exp_reg[r[18:16]];
            end
            2'h1: begin
               go(CLS_ROM, FMT_X, r[18:16], r[22:20], 32'h0, PRIM_RELEASE);
               exp_reg[r[22:20]] = ROM_CONSTS[r[18:16]];
            end
            default: begin
               go(CLS_ARITH, f, r[18:16], r[22:20], op, PRIM_XFER);
               exp_reg[r[22:20]] += sext(f, op);
            end
         endcase
      end
      drain("random");
      go(CLS_ROM, FMT_X, 3'h1, 3'h7, 32'h0, PRIM_RELEASE);
      go(CLS_ARITH, FMT_L, 3'h0, 3'h7, 32'hFFFF_FFFF, PRIM_XFER);
      go(CLS_ARITH, FMT_P, 3'h0, 3'h6, 32'h0, PRIM_EXC);
      go(CLS_ARITH, FMT_L, 3'h0, 3'h6, 32'h5, PRIM_XFER);
      exp_reg[7] = 32'h0;
      exp_reg[6] += 32'h5;
      drain("exception");
      summarize();
   end
   // watchdog against a hang
   initial begin
      #400000;
      miscompares++;
      summarize();
   end
endmodule // tb_top
`default_nettype wire
